// ==== core/bsr_pkg.sv ====
// Shared constants and types of the BiSS position reader
package bsr_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CFG = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_MAIN_LO = 5'h08;
	localparam logic [4:0] OFS_MAIN_HI = 5'h0c;
	localparam logic [4:0] OFS_AUX_LO = 5'h10;
	localparam logic [4:0] OFS_AUX_HI = 5'h14;
	// Configuration field positions
	localparam int CF_EN = 0;
	localparam int CF_AXIS = 1;
	localparam int CF_POL = 2;
	localparam int CF_PAD = 4;
	localparam int CF_N1 = 8;
	localparam int CF_N2 = 16;
	localparam int CF_DIV = 24;
	localparam logic [31:0] CFG_MASK = 32'h1f3f_ff7f;
	// Configuration values after reset
	localparam logic [4:0] DIV_DEF = 5'h09;
	localparam logic [1:0] POL_DEF = 2'h3;
	localparam logic [31:0] CFG_RST = (32'(DIV_DEF) << CF_DIV) | (32'(POL_DEF) << CF_POL);
	// Status word bits and status register fields
	localparam int SB_TMO = 0;
	localparam int SB_CRC = 1;
	localparam int SB_ERR = 2;
	localparam int SB_WRN = 3;
	localparam int ST_MAIN = 0;
	localparam int ST_AUX = 4;
	localparam int ST_CODE = 8;
	localparam int ST_BUSY = 16;
	// Frame layout and argument limits
	localparam int DATA_MAX = 38;
	localparam int DIV_MIN = 4;
	localparam int DIV_MAX = 26;
	localparam int FRAME_OVH = 11;
	localparam logic [5:0] FLAG_BITS = 6'h02;
	localparam logic [5:0] CRC_BITS = 6'h06;
	localparam logic [5:0] CRC_POLY = 6'h03;
	// Timing at the 40 MHz system clock
	localparam int CLK_PERIOD_NS = 25;
	localparam int START_TMO_NS = 30000;
	localparam int START_TMO_CYC = (START_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MA_STEP_NS = 100;
	localparam int MA_STEP_CYC = MA_STEP_NS / CLK_PERIOD_NS;
	// Error codes
	localparam logic [7:0] EC_RANGE = 8'h06;
	localparam logic [7:0] EC_NORESP = 8'h8c;
	localparam logic [7:0] EC_START = 8'h8f;
	localparam logic [7:0] EC_PERIOD = 8'ha8;
	// Frame sequencer states
	typedef enum logic [2:0] {
		BSR_IDLE = 3'h0,
		BSR_ACK = 3'h1,
		BSR_START = 3'h3,
		BSR_CDS = 3'h2,
		BSR_DATA = 3'h6,
		BSR_PAD = 3'h7,
		BSR_FLAG = 3'h5,
		BSR_CRC = 3'h4
	} bsr_state_e;
endpackage

// ==== core/bsr_reader.sv ====
// BiSS absolute encoder reader with Avalon-MM register access
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module bsr_reader import bsr_pkg::*; #(
	parameter int TICK_PERIOD_CYC = 40000,
	parameter int POS_W = 48
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Servo update tick, one-cycle pulse
	input wire logic servo_tick,
	// Encoder link
	output logic ma_clk,
	input wire logic enc_data,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Serial-error event, one-cycle pulse
	output logic serial_error_routine
);

	localparam int TMO_W = $clog2(START_TMO_CYC + 1);

	// Position must hold the widest field plus room to extend
	if (POS_W < DATA_MAX + 2 || POS_W > 64) begin : g_bad_pos
		$error("POS_W out of range");
	end
	if (TICK_PERIOD_CYC < 1) begin : g_bad_tick
		$error("TICK_PERIOD_CYC must be positive");
	end

	logic [31:0] cfg_q;
	logic [7:0] errc_q;
	logic [7:0] chk;
	bsr_state_e state_q;
	bsr_state_e nxt_s;
	logic [5:0] nxt_n;
	logic [5:0] half_q;
	logic [5:0] cnt_q;
	logic [TMO_W-1:0] tmo_q;
	logic [5:0] crc_q;
	logic [5:0] rxc_q;
	logic [DATA_MAX-1:0] raw_q;
	logic e_q;
	logic w_q;
	logic done_q;
	logic tmo_ev_q;
	logic [3:0] word;
	logic [31:0] stat_rd;
	logic [3:0] stat_q [2];
	logic [POS_W-1:0] pos_q [2];
	logic [DATA_MAX-1:0] prev_q [2];
	logic first_q [2];

	// Configuration fields
	wire cfg_en = cfg_q[CF_EN];
	wire cfg_aux = cfg_q[CF_AXIS];
	wire [1:0] cfg_pol = cfg_q[CF_POL +: 2];
	wire [2:0] cfg_pad = cfg_q[CF_PAD +: 3];
	wire cfg_cont = cfg_q[CF_N1 + 7];
	wire [5:0] cfg_n2 = cfg_q[CF_N2 +: 6];
	wire [4:0] cfg_div = cfg_q[CF_DIV +: 5];
	wire [5:0] half_len = 6'(((int'(cfg_div) + 1) * MA_STEP_CYC) / 2 - 1);

	// Bus strobes; a write lands on the edge that ends the wait
	wire wr_cfg = avs_write && !avs_waitrequest && avs_address == OFS_CFG;
	wire wr_stat = avs_write && !avs_waitrequest && avs_address == OFS_STAT;

	// Frame timing strobes
	wire go = servo_tick && cfg_en && state_q == BSR_IDLE;
	wire step = state_q != BSR_IDLE && half_q == 6'h00;
	wire rise = step && !ma_clk;
	wire waiting = state_q == BSR_ACK || state_q == BSR_START;
	wire tmo_hit = waiting && tmo_q == TMO_W'(START_TMO_CYC);
	wire fld_end = state_q == BSR_CDS || (cnt_q == 6'h01 && state_q inside {BSR_DATA, BSR_PAD, BSR_FLAG, BSR_CRC});
	wire [5:0] crc_nx = {crc_q[4:0], 1'b0} ^ ((crc_q[5] ^ enc_data) ? CRC_POLY : 6'h00);
	wire crc_bad = ~rxc_q != crc_q;
	wire err_act = cfg_pol[0] ? e_q : !e_q;
	wire wrn_act = cfg_pol[1] ? w_q : !w_q;
	wire upd = done_q || tmo_ev_q;

	// Wrap extension; the step is the shortest signed way round
	wire [POS_W-1:0] modv = POS_W'(1) << cfg_n2;
	wire [POS_W-1:0] dlt = (POS_W'(raw_q) - POS_W'(prev_q[cfg_aux])) & (modv - POS_W'(1));
	wire [POS_W-1:0] stepv = |(dlt & (modv >> 1)) ? dlt - modv : dlt;

	// Check a configuration word before it is taken
	function automatic logic [7:0] cfg_check(input logic [31:0] v);
		int n1;
		int n2;
		int dv;
		int cyc;
		n1 = int'(signed'(v[CF_N1 +: 8]));
		n2 = int'(v[CF_N2 +: 6]);
		dv = int'(v[CF_DIV +: 5]);
		cyc = (n2 + int'(v[CF_PAD +: 3]) + FRAME_OVH) * (dv + 1) * MA_STEP_CYC;
		cfg_check = 8'h00;
		if (n1 > DATA_MAX || n1 < -DATA_MAX || n2 > DATA_MAX || (n1 != n2 && n1 != -n2)
				|| dv < DIV_MIN || dv > DIV_MAX) begin
			cfg_check = EC_RANGE;
		end else if (v[CF_EN] && cyc > TICK_PERIOD_CYC) begin
			cfg_check = EC_PERIOD;
		end
	endfunction

	assign chk = cfg_check(avs_writedata);

	// A refused word leaves the running setup untouched
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= CFG_RST;
		end else if (wr_cfg && chk == 8'h00) begin
			cfg_q <= avs_writedata & CFG_MASK;
		end
	end

	// Last error code; a new error wins over a clearing write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			errc_q <= 8'h00;
		end else if (wr_cfg && chk != 8'h00) begin
			errc_q <= chk;
		end else if (tmo_hit) begin
			errc_q <= state_q == BSR_ACK ? EC_NORESP : EC_START;
		end else if (wr_stat) begin
			errc_q <= 8'h00;
		end
	end

	// Half-period divider of the MA clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_q <= 6'h00;
		end else if (go || step) begin
			half_q <= half_len;
		end else if (state_q != BSR_IDLE) begin
			half_q <= half_q - 6'h01;
		end
	end

	// MA line; idles high and is forced high on a timeout
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ma_clk <= 1'b1;
		end else if (go) begin
			ma_clk <= 1'b0;
		end else if (tmo_hit) begin
			ma_clk <= 1'b1;
		end else if (step) begin
			ma_clk <= !ma_clk;
		end
	end

	// Start bit timer, counted from the first MA edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmo_q <= '0;
		end else if (go) begin
			tmo_q <= '0;
		end else if (waiting) begin
			tmo_q <= tmo_q + TMO_W'(1);
		end
	end

	// Field that follows the current one; empty fields are skipped
	always_comb begin
		nxt_s = BSR_IDLE;
		nxt_n = 6'h00;
		if (state_q == BSR_CDS && cfg_n2 != 6'h00) begin
			nxt_s = BSR_DATA;
			nxt_n = cfg_n2;
		end else if (state_q inside {BSR_CDS, BSR_DATA} && cfg_pad != 3'h0) begin
			nxt_s = BSR_PAD;
			nxt_n = {3'h0, cfg_pad};
		end else if (state_q inside {BSR_CDS, BSR_DATA, BSR_PAD}) begin
			nxt_s = BSR_FLAG;
			nxt_n = FLAG_BITS;
		end else if (state_q == BSR_FLAG) begin
			nxt_s = BSR_CRC;
			nxt_n = CRC_BITS;
		end
	end

	// Frame sequencer; bits are sampled just before each MA rise
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= BSR_IDLE;
		end else if (go) begin
			state_q <= BSR_ACK;
		end else if (tmo_hit) begin
			state_q <= BSR_IDLE;
		end else if (rise) begin
			case (state_q)
				BSR_ACK: begin
					if (!enc_data) begin
						state_q <= BSR_START;
					end
				end
				BSR_START: begin
					if (enc_data) begin
						state_q <= BSR_CDS;
					end
				end
				BSR_DATA, BSR_PAD, BSR_FLAG, BSR_CRC, BSR_CDS: begin
					if (fld_end) begin
						state_q <= nxt_s;
					end
				end
				default: begin
					state_q <= BSR_IDLE;
				end
			endcase
		end
	end

	// Bit counter of the current field
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 6'h00;
		end else if (rise && fld_end) begin
			cnt_q <= nxt_n;
		end else if (rise && cnt_q != 6'h00) begin
			cnt_q <= cnt_q - 6'h01;
		end
	end

	// Position bits arrive MSB first
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_q <= '0;
		end else if (go) begin
			raw_q <= '0;
		end else if (rise && state_q == BSR_DATA) begin
			raw_q <= {raw_q[DATA_MAX-2:0], enc_data};
		end
	end

	// CRC runs over position, pad, error and warning bits
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_q <= 6'h00;
		end else if (go) begin
			crc_q <= 6'h00;
		end else if (rise && state_q inside {BSR_DATA, BSR_PAD, BSR_FLAG}) begin
			crc_q <= crc_nx;
		end
	end

	// Received CRC and the two flag bits, error first
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxc_q <= 6'h00;
			e_q <= 1'b0;
			w_q <= 1'b0;
		end else if (rise && state_q == BSR_CRC) begin
			rxc_q <= {rxc_q[4:0], enc_data};
		end else if (rise && state_q == BSR_FLAG && cnt_q == FLAG_BITS) begin
			e_q <= enc_data;
		end else if (rise && state_q == BSR_FLAG) begin
			w_q <= enc_data;
		end
	end

	// Frame-end and timeout events, one cycle each
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			tmo_ev_q <= 1'b0;
		end else begin
			done_q <= rise && state_q == BSR_CRC && cnt_q == 6'h01;
			tmo_ev_q <= tmo_hit;
		end
	end

	// Status word of a finished frame or a timeout
	always_comb begin
		word = 4'h0;
		word[SB_TMO] = tmo_ev_q;
		word[SB_CRC] = !tmo_ev_q && crc_bad;
		word[SB_ERR] = !tmo_ev_q && err_act;
		word[SB_WRN] = !tmo_ev_q && wrn_act;
	end

	// Per-axis status words, replaced whole
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q[0] <= 4'h0;
			stat_q[1] <= 4'h0;
		end else if (upd) begin
			stat_q[cfg_aux] <= word;
		end
	end

	// Serial-error event
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_error_routine <= 1'b0;
		end else begin
			serial_error_routine <= upd && word != 4'h0;
		end
	end

	// Positions; a frame with a bad CRC leaves them alone
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				pos_q[i] <= '0;
				prev_q[i] <= '0;
				first_q[i] <= 1'b1;
			end
		end else if (!cfg_en) begin
			first_q[0] <= 1'b1;
			first_q[1] <= 1'b1;
		end else if (done_q && !crc_bad) begin
			prev_q[cfg_aux] <= raw_q;
			first_q[cfg_aux] <= 1'b0;
			if (cfg_cont && !first_q[cfg_aux]) begin
				pos_q[cfg_aux] <= pos_q[cfg_aux] + stepv;
			end else begin
				pos_q[cfg_aux] <= POS_W'(raw_q);
			end
		end
	end

	// Status register layout
	always_comb begin
		stat_rd = 32'h0;
		stat_rd[ST_MAIN +: 4] = stat_q[0];
		stat_rd[ST_AUX +: 4] = stat_q[1];
		stat_rd[ST_CODE +: 8] = errc_q;
		stat_rd[ST_BUSY] = state_q != BSR_IDLE;
	end

	// One wait state per access keeps the read mux off the bus path
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read data, unmapped words read zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				OFS_CFG: avs_readdata <= cfg_q;
				OFS_STAT: avs_readdata <= stat_rd;
				OFS_MAIN_LO: avs_readdata <= pos_q[0][31:0];
				OFS_MAIN_HI: avs_readdata <= 32'(pos_q[0][POS_W-1:32]);
				OFS_AUX_LO: avs_readdata <= pos_q[1][31:0];
				OFS_AUX_HI: avs_readdata <= 32'(pos_q[1][POS_W-1:32]);
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	// Helper: length of the current MA low phase
	logic [6:0] lo_len;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lo_len <= 7'h00;
		end else begin
			lo_len <= ma_clk ? 7'h00 : lo_len + 7'h01;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_tick_burst: assert property (go |=> state_q == BSR_ACK && !ma_clk)
		else $error("tick did not start a burst");
	a_off_quiet: assert property (!cfg_en && state_q == BSR_IDLE |=> state_q == BSR_IDLE)
		else $error("burst while reading disabled");
	a_ma_half: assert property ($rose(ma_clk) && !$past(tmo_hit) |-> lo_len == {1'b0, half_len} + 7'h01)
		else $error("MA low phase length wrong");
	a_idle_high: assert property (state_q == BSR_IDLE |-> ma_clk)
		else $error("MA not high while idle");
	a_pos_at_end: assert property (pos_q[0] != $past(pos_q[0]) |-> $past(done_q))
		else $error("main position changed outside frame end");
	a_tmo_status: assert property (tmo_hit |=> ##1 stat_q[cfg_aux][SB_TMO] && serial_error_routine)
		else $error("timeout not reported");
	a_code_start: assert property (tmo_hit && state_q == BSR_START && !wr_cfg |=> errc_q == EC_START)
		else $error("start timeout code missing");
	a_code_noresp: assert property (tmo_hit && state_q == BSR_ACK && !wr_cfg |=> errc_q == EC_NORESP)
		else $error("no response code missing");
	a_crc_clear: assert property (done_q && !crc_bad |=> !stat_q[$past(cfg_aux)][SB_CRC])
		else $error("CRC flag not cleared");
	a_crc_event: assert property (done_q && crc_bad |=> serial_error_routine)
		else $error("CRC failure raised no event");
	a_err_pol: assert property (done_q |=> stat_q[$past(cfg_aux)][SB_ERR] == ($past(e_q) == $past(cfg_pol[0])))
		else $error("error bit polarity wrong");
	a_range_rej: assert property (wr_cfg && chk == EC_RANGE |=> cfg_q == $past(cfg_q) && errc_q == EC_RANGE)
		else $error("bad configuration taken");
	a_first_abs: assert property (done_q && !crc_bad && first_q[cfg_aux] |=> pos_q[$past(cfg_aux)] == POS_W'($past(raw_q)))
		else $error("first load not absolute");
	a_axis_route: assert property (done_q && !cfg_aux |=> pos_q[1] == $past(pos_q[1]))
		else $error("aux position written for main axis");

	c_frame_ok: cover property (done_q && !crc_bad);
	c_timeout: cover property (tmo_ev_q);
	c_crc_bad: cover property (done_q && crc_bad);
	c_reject: cover property (wr_cfg && chk != 8'h00);

endmodule // bsr_reader

// ==== verif/bsr_enc_model.sv ====
// Behavioural BiSS encoder that answers the reader's MA clock
`timescale 1ns/1ps
module bsr_enc_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Encoder link
	input wire logic ma_clk,
	output logic enc_data,
	// Frame to send MSB first, and fault mode (0 good, 1 silent, 2 never starts)
	input wire logic [63:0] frm_bits,
	input wire logic [6:0] frm_len,
	input wire logic [1:0] frm_mode
);
	logic ma_q;
	logic [7:0] quiet_q;
	logic [63:0] sh_q;
	logic [6:0] left_q;
	// Bits change one cycle after each MA fall, so they are settled long before the rising sample edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ma_q <= 1'b1;
			quiet_q <= 8'hff;
			sh_q <= 64'h0;
			left_q <= 7'h0;
			enc_data <= 1'b1;
		end else begin
			ma_q <= ma_clk;
			quiet_q <= !ma_clk ? 8'h00 : (quiet_q == 8'hff) ? quiet_q : quiet_q + 8'h01;
			if (ma_q && !ma_clk) begin
				if (frm_mode == 2'h1 || left_q == 7'h0)
					enc_data <= 1'b1;
				else if (frm_mode == 2'h2)
					enc_data <= 1'b0;
				else begin
					enc_data <= sh_q[63];
					sh_q <= {sh_q[62:0], 1'b0};
					left_q <= left_q - 7'h01;
				end
			end else if (quiet_q > 8'h96) begin
				// Long idle MA: line back at its idle high level, next frame loaded
				sh_q <= frm_bits;
				left_q <= frm_len;
				enc_data <= 1'b1;
			end
		end
	end
endmodule // bsr_enc_model

// ==== verif/bsr_reader_bench.sv ====
// Self-checking bench for the BiSS position reader
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %0t: got %h exp %h", $time, g, e); end end
module bsr_reader_bench import bsr_pkg::*;;
	localparam int TICK = 3000;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic servo_tick = 1'b0;
	logic ma_clk;
	logic enc_data;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic serial_error_routine;
	logic [63:0] frm_bits = 64'h0;
	logic [6:0] frm_len = 7'h0;
	logic [1:0] frm_mode = 2'h0;
	logic [31:0] good;
	logic [31:0] bad_w [5];
	logic [7:0] bad_c [5];
	logic e_x;
	logic w_x;
	int fails = 0;
	int total_checks = 0;
	int ev_cnt = 0;
	int lows = 0;

	bsr_reader #(.TICK_PERIOD_CYC(TICK), .POS_W(48)) bsr_reader_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.servo_tick(servo_tick), .ma_clk(ma_clk), .enc_data(enc_data), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_error_routine(serial_error_routine));
	bsr_enc_model bsr_enc_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ma_clk(ma_clk), .enc_data(enc_data),
		.frm_bits(frm_bits), .frm_len(frm_len), .frm_mode(frm_mode));

	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;
	// Count event pulses; cleared by each tick
	always @(posedge sys_clk) ev_cnt <= (servo_tick === 1'b1) ? 0 : ev_cnt + int'(serial_error_routine === 1'b1);

	// One bus access; request held until waitrequest is seen low at a rising edge
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Waitrequest and read data are both taken at the rising edge that ends the wait
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (avs_waitrequest !== 1'b0) fails++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		av(1'b1, a, d, q);
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		av(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	function automatic logic [31:0] cfg(logic en, logic ax, logic [1:0] pol, logic [2:0] pad, logic [7:0] n1,
		logic [5:0] n2, logic [4:0] dv);
		return {3'h0, dv, 2'h0, n2, n1, 1'h0, pad, pol, ax, en};
	endfunction
	function automatic logic [5:0] crc_step(logic [5:0] c, logic b);
		return {c[4:0], 1'b0} ^ ((c[5] ^ b) ? 6'h03 : 6'h00);
	endfunction

	// Build a frame (k ack bits, start, CDS, data, pad, E, W, inverted CRC), tick, wait for MA to rest
	task automatic send(input int k, input logic [37:0] d, input int n, input int p, input logic e,
		input logic w, input logic bad);
		logic [63:0] pb;
		logic [5:0] c;
		int pl;
		int q;
		pb = 64'h0;
		c = 6'h00;
		for (int i = n - 1; i >= 0; i--) pb = {pb[62:0], d[i]};
		pb = {pb << p, e, w};
		pl = n + p + 2;
		for (int i = pl - 1; i >= 0; i--) c = crc_step(c, pb[i]);
		frm_len = 7'(k + 2 + pl + 6);
		frm_bits = (((64'h2 << pl) | pb) << 6 | {58'h0, ~c ^ {5'h0, bad}}) << (64 - k - 2 - pl - 6);
		@(posedge sys_clk);
		servo_tick <= 1'b1;
		@(posedge sys_clk);
		servo_tick <= 1'b0;
		lows = 0;
		q = 0;
		for (int t = 0; t < 20000 && q < 200; t++) begin
			@(negedge sys_clk);
			q = (ma_clk === 1'b1) ? q + 1 : 0;
			if (ma_clk !== 1'b1) lows++;
		end
		// A line that never comes to rest is a failure, not a silent pass
		if (q < 200) fails++;
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// After reset: defaults, idle line, unmapped read, no bursts while disabled
	task automatic t_reset();
		chk_rd(OFS_CFG, 32'h0900_000c);
		chk_rd(OFS_STAT, 32'h0);
		chk_rd(5'h18, 32'h0);
		`CHK(ma_clk, 1'b1)
		send(1, 38'h1, 16, 0, 1'b0, 1'b0, 1'b0);
		`CHK(lows, 0)
	endtask
	// Absolute mode, including a wrap that must show as a jump
	task automatic t_abs();
		wr(OFS_CFG, cfg(1, 0, 3, 0, 8'd16, 6'd16, 5'd9));
		send(1, 38'ha5c3, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_MAIN_LO, 32'h0000_a5c3);
		chk_rd(OFS_STAT, 32'h0);
		`CHK(ev_cnt, 0)
		send(1, 38'hfffe, 16, 0, 1'b0, 1'b0, 1'b0);
		send(1, 38'h3, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_MAIN_LO, 32'h3);
	endtask
	// Every polarity setting with error active-high-level and warning low-level on the wire
	task automatic t_pol();
		for (int pol = 0; pol < 4; pol++) begin
			wr(OFS_CFG, cfg(1, 0, 2'(pol), 0, 8'd16, 6'd16, 5'd9));
			send(1, 38'h1234, 16, 0, 1'b1, 1'b0, 1'b0);
			e_x = pol[0];
			w_x = !pol[1];
			chk_rd(OFS_STAT, {28'h0, w_x, e_x, 2'h0});
			`CHK(ev_cnt, (e_x | w_x) ? 1 : 0)
		end
	endtask
	// Corrupt CRC keeps the old position; a good frame clears the flag
	task automatic t_crc();
		send(1, 38'h4321, 16, 0, 1'b0, 1'b0, 1'b0);
		send(1, 38'h0777, 16, 0, 1'b0, 1'b0, 1'b1);
		chk_rd(OFS_STAT, 32'h2);
		chk_rd(OFS_MAIN_LO, 32'h4321);
		`CHK(ev_cnt, 1)
		send(1, 38'h4321, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_STAT, 32'h0);
	endtask
	// Widest field, most padding, fastest divider, slow acknowledge, aux register
	task automatic t_aux();
		wr(OFS_CFG, cfg(1, 1, 3, 7, 8'd38, 6'd38, 5'd4));
		send(3, 38'h2a_5a5a_5a5a, 38, 7, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_AUX_LO, 32'h5a5a_5a5a);
		chk_rd(OFS_AUX_HI, 32'h2a);
		chk_rd(OFS_MAIN_LO, 32'h4321);
		chk_rd(OFS_STAT, 32'h0);
	endtask
	// Continuous mode: first frame loads as absolute, then wraps extend the count
	task automatic t_cont();
		wr(OFS_CFG, cfg(0, 0, 3, 0, 8'd16, 6'd16, 5'd9));
		wr(OFS_CFG, cfg(1, 0, 3, 0, 8'hf0, 6'd16, 5'd9));
		send(1, 38'hfffe, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_MAIN_HI, 32'h0);
		chk_rd(OFS_MAIN_LO, 32'h0000_fffe);
		send(1, 38'h3, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_MAIN_LO, 32'h0001_0003);
		send(1, 38'hfffd, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_MAIN_LO, 32'h0000_fffd);
	endtask
	// Silent encoder, then one that acknowledges but never starts
	task automatic t_tmo();
		wr(OFS_CFG, cfg(1, 0, 3, 0, 8'd16, 6'd16, 5'd9));
		frm_mode = 2'h1;
		send(1, 38'h1, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_STAT, 32'h0000_8c01);
		`CHK(ev_cnt, 1)
		`CHK(ma_clk, 1'b1)
		wr(OFS_STAT, 32'h0);
		chk_rd(OFS_STAT, 32'h1);
		frm_mode = 2'h2;
		send(1, 38'h1, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_STAT, 32'h0000_8f01);
		frm_mode = 2'h0;
		wr(OFS_STAT, 32'h0);
		send(1, 38'h1, 16, 0, 1'b0, 1'b0, 1'b0);
		chk_rd(OFS_STAT, 32'h0);
	endtask
	// Refused settings leave the stored word alone and leave a code
	task automatic t_cfg();
		good = cfg(1, 0, 3, 0, 8'd16, 6'd16, 5'd9);
		bad_w = '{cfg(1, 0, 3, 0, 8'd16, 6'd16, 5'd3), cfg(1, 0, 3, 0, 8'd16, 6'd16, 5'd27),
			cfg(1, 0, 3, 0, 8'd5, 6'd6, 5'd9), cfg(1, 0, 3, 0, 8'd39, 6'd39, 5'd9),
			cfg(1, 0, 3, 7, 8'd38, 6'd38, 5'd26)};
		bad_c = '{8'h06, 8'h06, 8'h06, 8'h06, 8'ha8};
		for (int i = 0; i < 5; i++) begin
			wr(OFS_STAT, 32'h0);
			wr(OFS_CFG, bad_w[i]);
			chk_rd(OFS_STAT, {16'h0, bad_c[i], 8'h00});
			chk_rd(OFS_CFG, good);
		end
	endtask

	// Watchdog: the whole run needs well under this many cycles
	initial begin
		repeat (80000) @(posedge sys_clk);
		fails++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_abs();
		t_pol();
		t_crc();
		t_aux();
		t_cont();
		t_tmo();
		t_cfg();
		summarize();
	end
endmodule // bsr_reader_bench
